// ===== pfs_pkg.sv
package pfs_pkg;

    // clock and time base
    localparam int          PFS_CLK_HZ    = 200_000_000;
    localparam int          PFS_US_PER_S  = 1_000_000;
    localparam logic [7:0]  PFS_US_CYCLES = 8'(PFS_CLK_HZ / PFS_US_PER_S);

    // motor timing figures, in their own units
    localparam int          PFS_STOP_HOLD_MS  = 10;
    localparam logic [15:0] PFS_STOP_HOLD_US  = 16'(PFS_STOP_HOLD_MS * 1000);
    localparam int          PFS_CUR_REDUCE_DELAY_US = 2000;
    localparam logic [15:0] PFS_CUR_REDUCE_US = 16'(PFS_CUR_REDUCE_DELAY_US);
    localparam int          PFS_LOAD_PPS      = 150;
    // least period: round up so loading never runs faster than the rate
    localparam logic [15:0] PFS_LOAD_STEP_US  =
        16'((PFS_US_PER_S + PFS_LOAD_PPS - 1) / PFS_LOAD_PPS);
    localparam int          PFS_SLOW_PPS      = 350;
    localparam logic [15:0] PFS_SLOW_STEP_US  = 16'(PFS_US_PER_S / PFS_SLOW_PPS);
    localparam logic [15:0] PFS_BACKLASH_STEPS = 16'h0010;
    localparam logic [4:0]  PFS_ACCEL_LAST    = 5'h12;

    // acceleration tables: entry 0 is the start hold, 18 the feed rate
    // (720 pps narrow model, 600 pps wider models)
    localparam int PFS_ACCEL_NARROW_US [19] = '{
        8000, 8000, 4950, 3831, 3215, 2817, 2538, 2326, 2155, 2020,
        1908, 1808, 1727, 1653, 1587, 1531, 1479, 1433, 1389};
    localparam int PFS_ACCEL_WIDE_US [19] = '{
        9615, 9615, 5952, 4608, 3861, 3378, 3049, 2793, 2591, 2427,
        2288, 2174, 2070, 1984, 1905, 1838, 1773, 1718, 1667};

    // register byte offsets
    localparam logic [7:0]  PFS_ADR_CTRL   = 8'h00;
    localparam logic [7:0]  PFS_ADR_COUNT  = 8'h04;
    localparam logic [7:0]  PFS_ADR_CFG    = 8'h08;
    localparam logic [7:0]  PFS_ADR_PULSE  = 8'h0C;
    localparam logic [7:0]  PFS_ADR_STATUS = 8'h10;
    localparam logic [7:0]  PFS_ADR_DONE   = 8'h14;

    // register field positions
    localparam int          PFS_CTRL_REV_BIT  = 3;
    localparam int          PFS_ST_BUSY_BIT   = 0;
    localparam int          PFS_ST_EN_BIT     = 1;
    localparam int          PFS_ST_PHASE_LSB  = 2;
    localparam int          PFS_ST_REV_BIT    = 4;
    localparam int          PFS_ST_PRINT_BIT  = 5;
    localparam int          PFS_ST_SLOW_BIT   = 6;
    localparam int          PFS_ST_STATE_LSB  = 8;

    // reset values
    localparam logic [15:0] PFS_COUNT_RST = 16'h0000;
    localparam logic [1:0]  PFS_MODEL_RST = 2'h0;
    localparam logic [15:0] PFS_PULSE_RST = 16'h0000;

    // command codes written to the control register
    localparam logic [2:0]  PFS_CMD_FEED  = 3'h1;
    localparam logic [2:0]  PFS_CMD_PRINT = 3'h2;
    localparam logic [2:0]  PFS_CMD_LOAD  = 3'h3;
    localparam logic [2:0]  PFS_CMD_INIT  = 3'h4;
    localparam logic [2:0]  PFS_CMD_STOP  = 3'h5;
    localparam logic [2:0]  PFS_CMD_PAUSE = 3'h6;

    // mechanism models
    localparam logic [1:0]  PFS_MODEL_NARROW = 2'h0;
    localparam logic [1:0]  PFS_MODEL_MID    = 2'h1;
    localparam logic [1:0]  PFS_MODEL_WIDE   = 2'h2;

    typedef enum logic [1:0] {PFS_MODE_FEED, PFS_MODE_PRINT, PFS_MODE_LOAD} pfs_mode_t;

    // driver control lines that travel together
    typedef struct packed {
        logic exc_off;
        logic sel_first;
        logic sel_second;
    } pfs_drive_t;

    localparam pfs_drive_t PFS_I_250 = 3'h0;
    localparam pfs_drive_t PFS_I_180 = 3'h2;
    localparam pfs_drive_t PFS_I_80  = 3'h1;
    localparam pfs_drive_t PFS_I_OFF = 3'h4;

    // phase pins {a, b} for excitation states 1..4
    localparam logic [1:0] PFS_PHASE_AB [4] = '{2'h1, 2'h3, 2'h2, 2'h0};

endpackage

// ===== pfs_step_len.sv
`timescale 1ns/1ps
module pfs_step_len (
    // step selection
    input  wire logic [1:0]        model_i,
    input  wire pfs_pkg::pfs_mode_t mode_i,
    input  wire logic [4:0]        idx_i,
    input  wire logic [15:0]       pulse_us_i,
    // length of the current step
    output logic      [15:0]       len_us_o
);

    logic [15:0] tab_us;

    // table lookup, then mode overrides
    always_comb begin
        if (model_i == pfs_pkg::PFS_MODEL_NARROW) begin
            tab_us = 16'(pfs_pkg::PFS_ACCEL_NARROW_US[idx_i]);
        end else begin
            tab_us = 16'(pfs_pkg::PFS_ACCEL_WIDE_US[idx_i]);
        end
        if (mode_i == pfs_pkg::PFS_MODE_LOAD) begin
            len_us_o = pfs_pkg::PFS_LOAD_STEP_US;
        end else if (mode_i == pfs_pkg::PFS_MODE_PRINT && pulse_us_i > tab_us) begin
            // stretching the step keeps the head burn inside one row
            len_us_o = pulse_us_i;
        end else begin
            len_us_o = tab_us;
        end
    end

endmodule

// ===== pfs_feed_ctrl.sv
`timescale 1ns/1ps
module pfs_feed_ctrl #(
    parameter logic [7:0]  US_CYCLES    = pfs_pkg::PFS_US_CYCLES,
    parameter logic [15:0] STOP_HOLD_US = pfs_pkg::PFS_STOP_HOLD_US
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // motor driver pins
    output logic             phase_in_a_o,
    output logic             phase_in_b_o,
    output logic             motor_disable_o,
    output logic             current_sel_first_o,
    output logic             current_sel_second_o,
    // status to the head logic
    output logic             print_allow_o,
    output logic             busy_o
);

    typedef enum logic [1:0] {PFS_ST_PAUSE, PFS_ST_START, PFS_ST_RUN, PFS_ST_HOLD} pfs_fsm_t;
    typedef enum logic [1:0] {PFS_BL_NONE, PFS_BL_REV, PFS_BL_FWD} pfs_bl_t;

    typedef struct packed {
        logic                ack;
        logic [31:0]         rdata;
        pfs_fsm_t            st;
        pfs_pkg::pfs_mode_t  mode;
        logic                dir;
        pfs_bl_t             bl;
        logic [4:0]          idx;
        logic [1:0]          phase;
        logic [7:0]          pre;
        logic [15:0]         step_us;
        logic [15:0]         done;
        logic                stop_req;
        logic [2:0]          cmd_last;
        logic                rev_last;
        logic [1:0]          model;
        logic [15:0]         count;
        logic [15:0]         pulse_us;
        pfs_pkg::pfs_drive_t drive;
        logic [1:0]          pins_ab;
        logic                print_allow;
        logic                busy;
        logic                slow;
    } pfs_state_t;

    localparam pfs_state_t PFS_STATE_RST = '{
        ack:         1'b0,
        rdata:       32'h0000_0000,
        st:          PFS_ST_PAUSE,
        mode:        pfs_pkg::PFS_MODE_FEED,
        dir:         1'b0,
        bl:          PFS_BL_NONE,
        idx:         5'h00,
        phase:       2'h0,
        pre:         8'h00,
        step_us:     16'h0000,
        done:        16'h0000,
        stop_req:    1'b0,
        cmd_last:    3'h0,
        rev_last:    1'b0,
        model:       pfs_pkg::PFS_MODEL_RST,
        count:       pfs_pkg::PFS_COUNT_RST,
        pulse_us:    pfs_pkg::PFS_PULSE_RST,
        drive:       pfs_pkg::PFS_I_OFF,
        pins_ab:     pfs_pkg::PFS_PHASE_AB[0],
        print_allow: 1'b0,
        busy:        1'b0,
        slow:        1'b0
    };

    pfs_state_t  s_reg;
    pfs_state_t  s_next;
    logic [15:0] len_us;
    logic [31:0] wmask;

    // byte lanes of a write
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
        end
    endgenerate

    // length of the step now being output
    pfs_step_len pfs_step_len_inst (
        .model_i    (s_reg.model),
        .mode_i     (s_reg.mode),
        .idx_i      (s_reg.idx),
        .pulse_us_i (s_reg.pulse_us),
        .len_us_o   (len_us)
    );

    // next state
    always_comb begin
        logic        req;
        logic        wr;
        logic        tick;
        logic        bound;
        logic        step;
        logic        go;
        logic [2:0]  cmd;
        logic [15:0] lim;
        logic [31:0] wval;
        s_next = s_reg;
        req    = wb_cyc_i & wb_stb_i;
        // a write takes effect at the edge where the master sees ack
        wr     = req & wb_we_i & s_reg.ack;
        tick   = (s_reg.pre == US_CYCLES - 8'h01);
        step   = 1'b0;
        go     = 1'b0;
        cmd    = 3'h0;
        wval   = 32'h0000_0000;
        lim    = (s_reg.st == PFS_ST_HOLD) ? STOP_HOLD_US : len_us;
        bound  = tick && (s_reg.step_us == lim - 16'h0001);

        // microsecond time base and position inside the step
        s_next.pre = tick ? 8'h00 : s_reg.pre + 8'h01;
        if (tick && s_reg.step_us != 16'hFFFF) begin
            s_next.step_us = s_reg.step_us + 16'h0001;
        end

        // sequencer timing
        unique case (s_reg.st)
            PFS_ST_PAUSE: begin
                s_next.step_us = 16'h0000;
            end
            PFS_ST_START: begin
                if (bound) begin
                    s_next.st  = PFS_ST_RUN;
                    s_next.idx = 5'h01;
                    step       = 1'b1;
                end
            end
            PFS_ST_RUN: begin
                if (bound) begin
                    s_next.done = s_reg.done + 16'h0001;
                    if (s_next.done == s_reg.count || s_reg.stop_req) begin
                        s_next.stop_req = 1'b0;
                        s_next.done     = 16'h0000;
                        if (s_reg.bl == PFS_BL_REV) begin
                            // take up backlash in the feed direction
                            s_next.bl    = PFS_BL_FWD;
                            s_next.dir   = 1'b0;
                            s_next.count = pfs_pkg::PFS_BACKLASH_STEPS;
                            s_next.idx   = 5'h01;
                            step         = 1'b1;
                        end else if (s_reg.bl == PFS_BL_NONE && s_reg.dir) begin
                            s_next.bl    = PFS_BL_REV;
                            s_next.count = pfs_pkg::PFS_BACKLASH_STEPS;
                            step         = 1'b1;
                        end else begin
                            s_next.bl      = PFS_BL_NONE;
                            s_next.st      = PFS_ST_HOLD;
                            s_next.step_us = 16'h0000;
                            s_next.pre     = 8'h00;
                        end
                    end else begin
                        step = 1'b1;
                        if (s_reg.idx != pfs_pkg::PFS_ACCEL_LAST) begin
                            s_next.idx = s_reg.idx + 5'h01;
                        end
                    end
                end
            end
            PFS_ST_HOLD: begin
                if (bound) begin
                    s_next.st = PFS_ST_PAUSE;
                end
            end
        endcase

        // register writes
        if (wr) begin
            unique case (wb_adr_i)
                pfs_pkg::PFS_ADR_CTRL: begin
                    if (wb_sel_i[0]) begin
                        cmd             = wb_dat_i[2:0];
                        s_next.cmd_last = cmd;
                        s_next.rev_last = wb_dat_i[pfs_pkg::PFS_CTRL_REV_BIT];
                    end
                end
                pfs_pkg::PFS_ADR_COUNT: begin
                    wval         = ({16'h0000, s_reg.count} & ~wmask) | (wb_dat_i & wmask);
                    s_next.count = wval[15:0];
                end
                pfs_pkg::PFS_ADR_CFG: begin
                    wval         = ({30'h0, s_reg.model} & ~wmask) | (wb_dat_i & wmask);
                    s_next.model = wval[1:0];
                end
                pfs_pkg::PFS_ADR_PULSE: begin
                    wval            = ({16'h0000, s_reg.pulse_us} & ~wmask) | (wb_dat_i & wmask);
                    s_next.pulse_us = wval[15:0];
                end
                default: begin
                end
            endcase
        end

        // commands: runs start only from the stop step or from pause
        if (s_reg.st == PFS_ST_PAUSE || s_reg.st == PFS_ST_HOLD) begin
            if (cmd == pfs_pkg::PFS_CMD_FEED && s_reg.count != 16'h0000) begin
                s_next.mode = pfs_pkg::PFS_MODE_FEED;
                s_next.dir  = wb_dat_i[pfs_pkg::PFS_CTRL_REV_BIT];
                go          = 1'b1;
            end else if (cmd == pfs_pkg::PFS_CMD_PRINT && s_reg.count != 16'h0000) begin
                s_next.mode = pfs_pkg::PFS_MODE_PRINT;
                s_next.dir  = 1'b0;
                go          = 1'b1;
            end else if (cmd == pfs_pkg::PFS_CMD_LOAD && s_reg.count != 16'h0000) begin
                s_next.mode = pfs_pkg::PFS_MODE_LOAD;
                s_next.dir  = 1'b0;
                go          = 1'b1;
            end else if (cmd == pfs_pkg::PFS_CMD_INIT) begin
                s_next.mode  = pfs_pkg::PFS_MODE_FEED;
                s_next.dir   = 1'b1;
                s_next.bl    = PFS_BL_REV;
                s_next.count = pfs_pkg::PFS_BACKLASH_STEPS;
                go           = 1'b1;
            end else if (cmd == pfs_pkg::PFS_CMD_PAUSE && s_reg.st == PFS_ST_HOLD) begin
                s_next.st = PFS_ST_PAUSE;
            end
        end else if (cmd == pfs_pkg::PFS_CMD_STOP) begin
            s_next.stop_req = 1'b1;
        end
        if (go) begin
            s_next.done     = 16'h0000;
            s_next.stop_req = 1'b0;
            if (cmd != pfs_pkg::PFS_CMD_INIT) begin
                s_next.bl = PFS_BL_NONE;
            end
            if (s_reg.st == PFS_ST_HOLD) begin
                s_next.st  = PFS_ST_RUN;
                s_next.idx = 5'h01;
                step       = 1'b1;
            end else begin
                // stop phase held for the start-step time before moving
                s_next.st      = PFS_ST_START;
                s_next.idx     = 5'h00;
                s_next.step_us = 16'h0000;
                s_next.pre     = 8'h00;
            end
        end

        // step boundary: next excitation state, restart step timing
        if (step) begin
            // ascending state order turns the shaft clockwise, one dot row a step
            s_next.phase   = s_next.dir ? s_reg.phase - 2'h1 : s_reg.phase + 2'h1;
            s_next.step_us = 16'h0000;
            s_next.pre     = 8'h00;
        end

        // pin values, taken from the next state so all change together
        s_next.pins_ab = pfs_pkg::PFS_PHASE_AB[s_next.phase];
        unique case (s_next.st)
            PFS_ST_PAUSE: s_next.drive = pfs_pkg::PFS_I_OFF;
            PFS_ST_START: s_next.drive = pfs_pkg::PFS_I_180;
            PFS_ST_HOLD:  s_next.drive = pfs_pkg::PFS_I_180;
            PFS_ST_RUN: begin
                if (s_next.mode == pfs_pkg::PFS_MODE_LOAD) begin
                    s_next.drive = (s_next.model == pfs_pkg::PFS_MODEL_NARROW) ?
                                   pfs_pkg::PFS_I_180 : pfs_pkg::PFS_I_250;
                end else if (s_next.mode == pfs_pkg::PFS_MODE_PRINT &&
                             s_next.model != pfs_pkg::PFS_MODEL_WIDE &&
                             s_next.step_us >= pfs_pkg::PFS_CUR_REDUCE_US) begin
                    // cuts motor heating on long print steps
                    s_next.drive = pfs_pkg::PFS_I_80;
                end else begin
                    s_next.drive = pfs_pkg::PFS_I_180;
                end
            end
        endcase
        // printing may overlap acceleration but never reverse motion
        s_next.busy        = (s_next.st == PFS_ST_START || s_next.st == PFS_ST_RUN);
        s_next.print_allow = s_next.busy &&
                             s_next.mode == pfs_pkg::PFS_MODE_PRINT && !s_next.dir;
        // warns software of a noisy slow run; loading is slow by design
        s_next.slow = (s_reg.st == PFS_ST_RUN) && s_reg.mode != pfs_pkg::PFS_MODE_LOAD &&
                      len_us >= pfs_pkg::PFS_SLOW_STEP_US;

        // bus answer, one cycle after the request, dropped the next cycle
        s_next.ack   = req & ~s_reg.ack;
        s_next.rdata = 32'h0000_0000;
        if (req & ~s_reg.ack & ~wb_we_i) begin
            unique case (wb_adr_i)
                pfs_pkg::PFS_ADR_CTRL:   s_next.rdata = {28'h0, s_reg.rev_last, s_reg.cmd_last};
                pfs_pkg::PFS_ADR_COUNT:  s_next.rdata = {16'h0000, s_reg.count};
                pfs_pkg::PFS_ADR_CFG:    s_next.rdata = {30'h0, s_reg.model};
                pfs_pkg::PFS_ADR_PULSE:  s_next.rdata = {16'h0000, s_reg.pulse_us};
                pfs_pkg::PFS_ADR_STATUS: begin
                    s_next.rdata[pfs_pkg::PFS_ST_BUSY_BIT] = s_reg.busy;
                    s_next.rdata[pfs_pkg::PFS_ST_EN_BIT]   = ~s_reg.drive.exc_off;
                    s_next.rdata[pfs_pkg::PFS_ST_PHASE_LSB +: 2] = s_reg.phase;
                    s_next.rdata[pfs_pkg::PFS_ST_REV_BIT]   = s_reg.dir;
                    s_next.rdata[pfs_pkg::PFS_ST_PRINT_BIT] = s_reg.print_allow;
                    s_next.rdata[pfs_pkg::PFS_ST_SLOW_BIT]  = s_reg.slow;
                    s_next.rdata[pfs_pkg::PFS_ST_STATE_LSB +: 2] = s_reg.st;
                end
                pfs_pkg::PFS_ADR_DONE:   s_next.rdata = {16'h0000, s_reg.done};
                default:                 s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= PFS_STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register
    assign wb_dat_o             = s_reg.rdata;
    assign wb_ack_o             = s_reg.ack;
    assign phase_in_a_o         = s_reg.pins_ab[1];
    assign phase_in_b_o         = s_reg.pins_ab[0];
    assign motor_disable_o      = s_reg.drive.exc_off;
    assign current_sel_first_o  = s_reg.drive.sel_first;
    assign current_sel_second_o = s_reg.drive.sel_second;
    assign print_allow_o        = s_reg.print_allow;
    assign busy_o               = s_reg.busy;

endmodule

// ===== pfs_motor_model.sv
`timescale 1ns/1ps
module pfs_motor_model (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // driver inputs
    input  wire logic               phase_in_a_i,
    input  wire logic               phase_in_b_i,
    input  wire logic               motor_disable_i,
    input  wire logic               current_sel_first_i,
    input  wire logic               current_sel_second_i,
    // paper position in dot rows of 0.125 mm, and winding current
    output logic signed [15:0]      position_o,
    output logic        [8:0]       current_ma_o
);
    logic [1:0] idx_now;
    logic [1:0] idx_old;

    // excitation state 1..4 as index 0..3
    assign idx_now = {~phase_in_b_i, ~(phase_in_a_i ^ phase_in_b_i)};

    // unexcited shaft still holds the paper, so no move while disabled
    always_ff @(posedge clk_i) begin
        idx_old <= idx_now;
        if (rst_i) begin
            position_o <= 16'sh0000;
        end else if (!motor_disable_i && idx_now == idx_old + 2'h1) begin
            position_o <= position_o + 16'sh0001;
        end else if (!motor_disable_i && idx_now == idx_old - 2'h1) begin
            position_o <= position_o - 16'sh0001;
        end
    end

    // chopper current from the select lines; 11 is not a legal setting
    always_comb begin
        case ({motor_disable_i, current_sel_first_i, current_sel_second_i})
            3'h0:    current_ma_o = 9'h0FA;
            3'h2:    current_ma_o = 9'h0B4;
            3'h1:    current_ma_o = 9'h050;
            default: current_ma_o = 9'h000;
        endcase
    end
endmodule

// ===== pfs_feed_ctrl_assertions.sv
`timescale 1ns/1ps
module pfs_feed_ctrl_assertions #(
    parameter logic [7:0]  US_CYCLES    = pfs_pkg::PFS_US_CYCLES,
    parameter logic [15:0] STOP_HOLD_US = pfs_pkg::PFS_STOP_HOLD_US
) (
    // clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    // motor side
    input wire logic        phase_in_a_o,
    input wire logic        phase_in_b_o,
    input wire logic        motor_disable_o,
    input wire logic        current_sel_first_o,
    input wire logic        current_sel_second_o,
    input wire logic        print_allow_o,
    input wire logic        busy_o
);
    localparam int MIN_STEP = 1389 * int'(US_CYCLES) - 2;
    localparam int HOLD_CYC = int'(STOP_HOLD_US) * int'(US_CYCLES);
    int step_cnt;
    int idle_cnt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // cycles since the last phase change, and since the run ended
    always_ff @(posedge clk_i) begin
        if (rst_i || !busy_o || $changed({phase_in_a_o, phase_in_b_o})) begin
            step_cnt <= 0;
        end else begin
            step_cnt <= step_cnt + 1;
        end
        idle_cnt <= (rst_i || busy_o) ? 0 : idle_cnt + 1;
    end

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_ack_resp: assert property (s_req |=> s_ack_once)
        else $error("ack not a single pulse after request");
    a_ack_idle: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack without request");
    a_phase_adj: assert property ($changed({phase_in_a_o, phase_in_b_o}) |->
        ($changed(phase_in_a_o) != $changed(phase_in_b_o)))
        else $error("phase skipped a state");
    a_print_fwd: assert property (print_allow_o && $past(print_allow_o) &&
        $changed({phase_in_a_o, phase_in_b_o}) |-> phase_in_a_o == $past(phase_in_b_o))
        else $error("reverse step while print allowed");
    a_run_excited: assert property (busy_o |-> !motor_disable_o)
        else $error("motor disabled while running");
    a_start_cur: assert property ($rose(busy_o) && $past(motor_disable_o) |->
        {current_sel_first_o, current_sel_second_o} == 2'h2)
        else $error("start step not at 180 mA");
    a_sel_legal: assert property (!(current_sel_first_o && current_sel_second_o))
        else $error("illegal current select");
    a_low_cur: assert property (current_sel_second_o && !current_sel_first_o |-> busy_o)
        else $error("80 mA outside a run");
    a_step_min: assert property ($changed({phase_in_a_o, phase_in_b_o}) && step_cnt > 8
        |-> step_cnt >= MIN_STEP)
        else $error("step shorter than fastest table step");
    a_hold_len: assert property ($rose(motor_disable_o) && idle_cnt > 0 |->
        idle_cnt >= HOLD_CYC - 3 && idle_cnt <= HOLD_CYC + 3)
        else $error("stop hold length wrong");
endmodule

bind pfs_feed_ctrl pfs_feed_ctrl_assertions #(
    .US_CYCLES(US_CYCLES),
    .STOP_HOLD_US(STOP_HOLD_US)
) pfs_feed_ctrl_assertions_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .phase_in_a_o(phase_in_a_o), .phase_in_b_o(phase_in_b_o),
    .motor_disable_o(motor_disable_o), .current_sel_first_o(current_sel_first_o),
    .current_sel_second_o(current_sel_second_o), .print_allow_o(print_allow_o),
    .busy_o(busy_o)
);

// ===== pfs_feed_ctrl_test.sv
`timescale 1ns/1ps
module pfs_feed_ctrl_test;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, ph_a, ph_b, dis, s1, s2, pa, busy;
    logic signed [15:0] pos;
    logic [8:0]  ma;
    logic [15:0] pulse;
    logic [31:0] exp_q[$];
    logic [7:0]  a_list[6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    int error_cnt = 0, n_tests = 0, cyc_cnt = 0, t = 0, seed = 32'h2959bdac;

    // 200 MHz
    always #2.5 clk_i = ~clk_i;

    // short us tick and stop hold keep the run small
    pfs_feed_ctrl #(.US_CYCLES(8'h02), .STOP_HOLD_US(16'h0014)) pfs_feed_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .phase_in_a_o(ph_a), .phase_in_b_o(ph_b), .motor_disable_o(dis),
        .current_sel_first_o(s1), .current_sel_second_o(s2), .print_allow_o(pa),
        .busy_o(busy));
    pfs_motor_model pfs_motor_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .phase_in_a_i(ph_a), .phase_in_b_i(ph_b),
        .motor_disable_i(dis), .current_sel_first_i(s1), .current_sel_second_i(s2),
        .position_o(pos), .current_ma_o(ma));

    task automatic fail(input string m);
        error_cnt++;
        $display("mismatch %0t %s", $time, m);
    endtask
    task automatic chk_val(input logic [31:0] e, input logic [31:0] g, input string m);
        n_tests++;
        if (g !== e) fail(m);
    endtask
    // step times are checked within a few cycles of the expected figure
    task automatic chk_win(input int g, input int e, input string m);
        n_tests++;
        if (g < e - 6 || g > e + 6) fail(m);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // classic single cycle; request held until ack is sampled
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hF;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    // cycles until the paper reaches row p, or until 40000 cycles pass
    task automatic wait_pos(input logic signed [15:0] p);
        t = 0;
        while (pos !== p && t < 40000) begin @(posedge clk_i); t++; end
    endtask
    task automatic wait_idle(input logic lvl);
        t = 0;
        while ((lvl ? dis : busy) !== lvl && t < 40000) begin @(posedge clk_i); t++; end
    endtask

    // read data is taken at the edge where ack is sampled high
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) chk_val(exp_q.pop_front(), rdat, "read");
    end
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 95000) begin fail("timeout"); wrap_up(); end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) rd(a_list[i], 32'h0);
        chk_val(32'(dis), 32'h1, "idle not disabled");
        pulse = 16'($random(seed)) & 16'h07FF;
        bus(pfs_pkg::PFS_ADR_PULSE, 1'b1, {16'h0, pulse});
        rd(pfs_pkg::PFS_ADR_PULSE, {16'h0, pulse});
        bus(pfs_pkg::PFS_ADR_STATUS, 1'b1, 32'hFFFFFFFF);
        rd(pfs_pkg::PFS_ADR_STATUS, 32'h0);
        $display("registers done");
        bus(pfs_pkg::PFS_ADR_COUNT, 1'b1, 32'h2);
        bus(pfs_pkg::PFS_ADR_CTRL, 1'b1, {29'h0, pfs_pkg::PFS_CMD_FEED});
        repeat (3) @(posedge clk_i);
        chk_val({29'h0, dis, s1, s2}, 32'h2, "start current");
        wait_pos(16'sh0001);
        chk_win(t, 15997, "start hold");
        chk_val(32'(ma), 32'hB4, "feed current");
        rd(pfs_pkg::PFS_ADR_STATUS, 32'h0000_0247);
        wait_pos(16'sh0002);
        chk_win(t, 16000, "first step");
        wait_idle(1'b0);
        chk_win(t, 9900, "second step");
        $display("feed done");
        bus(pfs_pkg::PFS_ADR_CTRL, 1'b1, {29'h0, pfs_pkg::PFS_CMD_PRINT});
        wait_pos(16'sh0003);
        chk_win(t, 2, "restart from hold");
        repeat (4200) @(posedge clk_i);
        chk_val({29'h0, dis, s1, s2}, 32'h1, "reduced current");
        chk_val(32'(pa), 32'h1, "print allow");
        wait_idle(1'b0);
        wait_idle(1'b1);
        chk_win(t, 40, "stop hold");
        chk_val(32'(ma), 32'h0, "pause current");
        chk_val(32'(pos), 32'h4, "paper rows");
        rd(pfs_pkg::PFS_ADR_STATUS, 32'h0);
        $display("print done");
        wrap_up();
    end
endmodule
